// [hw/rrs_clock_div.sv]
// Purpose: dot clock derived from the operating clock
// Assumes: divide ratio of two or more
// Notes:   output is a registered toggle
`timescale 1ns/1ns
module rrs_clock_div
  import rrs_pkg::*;
#(
  parameter int DIV = RRS_DOT_DIV
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic run,
  output logic      dot_clk
);

  logic [7:0] cnt_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= 8'h00;
      dot_clk <= 1'b0;
    end else if (!run) begin
      cnt_reg <= 8'h00;
      dot_clk <= 1'b0;
    end else if (cnt_reg == 8'(DIV / 2 - 1)) begin
      cnt_reg <= 8'h00;
      dot_clk <= ~dot_clk; // [R12]
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end

endmodule

// [hw/rrs_pkg.sv]
// Purpose: shared constants and types for renderer reset/state control
// Assumes: single 50 MHz clock domain
// Notes:   mode patterns and timing counts live here
package rrs_pkg;

  typedef enum logic [2:0] {
    RRS_ST_POWER_ON,
    RRS_ST_INITIAL,
    RRS_ST_RESET,
    RRS_ST_MEM_INIT,
    RRS_ST_NORMAL
  } rrs_state_e;

  localparam logic [2:0] RRS_MODE_0     = 3'h0;
  localparam logic [2:0] RRS_MODE_1     = 3'h1;
  localparam logic [2:0] RRS_MODE_2     = 3'h2;
  localparam int         RRS_CLK_MHZ    = 50;
  localparam int         RRS_INIT_US    = 200;
  localparam int         RRS_INIT_CYC   = RRS_INIT_US * RRS_CLK_MHZ;
  localparam int         RRS_REFRESH_CYC = 390;
  localparam int         RRS_DOT_DIV    = 2;
  localparam int         RRS_MD_W       = 32;
  localparam int         RRS_HD_W       = 16;
  localparam int         RRS_IRQ_N      = 8;
  localparam int         RRS_R_POS      = 11;
  localparam int         RRS_G_POS      = 5;
  localparam int         RRS_B_POS      = 0;

  // interrupt flag positions
  localparam int RRS_IRQ_SYNC_ERR  = 0;
  localparam int RRS_IRQ_FRAME     = 1;
  localparam int RRS_IRQ_DMA       = 2;
  localparam int RRS_IRQ_CMD_ERR   = 3;
  localparam int RRS_IRQ_VBLANK    = 4;
  localparam int RRS_IRQ_TRAP      = 5;
  localparam int RRS_IRQ_SUSPEND   = 6;
  localparam int RRS_IRQ_BREAK     = 7;

  typedef struct packed {
    logic [4:0] red;
    logic [5:0] green;
    logic [4:0] blue;
  } rrs_rgb_s;

  typedef struct packed {
    logic display_period_out;
    logic colour_detect_out;
    logic dma_request_out;
    logic interrupt_request_out;
    logic wait_out;
  } rrs_pins_s;

endpackage

// [hw/rrs_state_ctrl.sv]
// Purpose: processing state and reset control of the renderer
// Assumes: pins sampled synchronously to clk
// Notes:   drawing/display engines live outside; this gates them
`timescale 1ns/1ns

// Overview of operation
// [R1] five processing states tracked by controller
// [R2] pins undefined before first reset
// [R3] no memory refresh while reset low
// [R4] latch mode pins on reset rising edge
// [R5] host keeps mode pins at legal patterns
// [R6] defined pin levels right after reset
// [R7] memory data bus driven low in reset
// [R8] host bus drives only when read low
// [R9] initialize memory before normal operation
// [R10] normal state runs drawing and display
// [R11] operating clock feeds all but display
// [R12] dot clock half rate, capped
// [R13] interrupt from eight flag sources
// [R14] colour conversion gives 5-6-5 pixel
// [R15] memory init after release and capture
module rrs_state_ctrl
  import rrs_pkg::*;
#(
  parameter int INIT_CYC    = RRS_INIT_CYC,
  parameter int REFRESH_CYC = RRS_REFRESH_CYC
) (
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  input  wire logic                 reset_pin_b,
  input  wire logic                 op_select_pin0,
  input  wire logic                 op_select_pin1,
  input  wire logic                 op_select_pin2,
  input  wire logic                 host_read_b,
  input  wire logic [RRS_HD_W-1:0]  host_rd_data,
  input  wire logic [RRS_IRQ_N-1:0] irq_events,
  input  wire logic [RRS_IRQ_N-1:0] irq_clear,
  input  wire logic                 draw_active,
  input  wire logic                 display_period_out_period,
  input  wire logic                 colour_hit,
  input  wire logic                 dma_req,
  input  wire logic                 host_wait,
  input  wire logic [23:0]          yuv_rgb_in,
  output rrs_state_e                state,
  output logic [2:0]                op_mode,
  output logic                      mode_illegal,
  output logic [RRS_MD_W-1:0]       gfx_mem_data_bus_o,
  output logic                      gfx_mem_data_bus_oe,
  output logic [RRS_HD_W-1:0]       host_data_bus_o,
  output logic                      host_data_bus_oe,
  output logic                      vertical_sync_pin_oe,
  output logic                      horizontal_sync_pin_oe,
  output logic                      odd_field_pin_oe,
  output rrs_pins_s                 pins,
  output logic                      refresh_req,
  output logic                      mem_init_busy,
  output logic                      engine_run,
  output logic                      dot_clk,
  output logic [RRS_IRQ_N-1:0]      irq_flags,
  output rrs_rgb_s                  pixel_out
);

  logic        rst_pin_d_reg;
  logic [31:0] init_cnt_reg;
  logic [31:0] ref_cnt_reg;
  logic        in_reset;

  function automatic logic mode_ok(input logic [2:0] m);
    mode_ok = (m == RRS_MODE_0) || (m == RRS_MODE_1) ||
              (m == RRS_MODE_2); // [R5]
  endfunction

  assign in_reset = !reset_pin_b;

  ////////////////////////////////////////////////////////////////////////////
  // state sequencing
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= RRS_ST_POWER_ON; // [R2]
    end else if (in_reset) begin
      state <= RRS_ST_RESET; // [R1]
    end else begin
      unique case (state)
        RRS_ST_POWER_ON: state <= RRS_ST_INITIAL;
        RRS_ST_INITIAL:  state <= RRS_ST_INITIAL;
        RRS_ST_RESET:    state <= RRS_ST_MEM_INIT; // [R15]
        RRS_ST_MEM_INIT: begin
          if (init_cnt_reg == 32'(INIT_CYC - 1)) begin
            state <= RRS_ST_NORMAL; // [R9]
          end
        end
        RRS_ST_NORMAL:   state <= RRS_ST_NORMAL;
        default:         state <= RRS_ST_RESET;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_pin_d_reg <= 1'b0;
    end else begin
      rst_pin_d_reg <= reset_pin_b;
    end
  end

  // mode capture on reset release
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      op_mode      <= RRS_MODE_0;
      mode_illegal <= 1'b0;
    end else if (reset_pin_b && !rst_pin_d_reg) begin
      op_mode      <= {op_select_pin2, op_select_pin1, op_select_pin0}; // [R4]
      mode_illegal <= !mode_ok({op_select_pin2, op_select_pin1,
                                op_select_pin0});
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // memory initialization and refresh
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      init_cnt_reg  <= 32'h0;
      mem_init_busy <= 1'b0;
    end else if (state == RRS_ST_MEM_INIT && !in_reset) begin
      init_cnt_reg  <= init_cnt_reg + 32'h1;
      mem_init_busy <= init_cnt_reg != 32'(INIT_CYC - 1); // [R9]
    end else begin
      init_cnt_reg  <= 32'h0;
      mem_init_busy <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ref_cnt_reg <= 32'h0;
      refresh_req <= 1'b0;
    end else if (in_reset || state != RRS_ST_NORMAL) begin
      ref_cnt_reg <= 32'h0;
      refresh_req <= 1'b0; // [R3]
    end else if (ref_cnt_reg == 32'(REFRESH_CYC - 1)) begin
      ref_cnt_reg <= 32'h0;
      refresh_req <= 1'b1;
    end else begin
      ref_cnt_reg <= ref_cnt_reg + 32'h1;
      refresh_req <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin states
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gfx_mem_data_bus_o     <= '0;
      gfx_mem_data_bus_oe    <= 1'b0;
      host_data_bus_o        <= '0;
      host_data_bus_oe       <= 1'b0;
      vertical_sync_pin_oe   <= 1'b0;
      horizontal_sync_pin_oe <= 1'b0;
      odd_field_pin_oe       <= 1'b0;
    end else if (in_reset) begin
      gfx_mem_data_bus_o     <= '0; // [R7]
      gfx_mem_data_bus_oe    <= 1'b1; // [R7]
      host_data_bus_o        <= '0;
      host_data_bus_oe       <= !host_read_b; // [R8]
      vertical_sync_pin_oe   <= 1'b0; // [R6]
      horizontal_sync_pin_oe <= 1'b0; // [R6]
      odd_field_pin_oe       <= 1'b0; // [R6]
    end else begin
      gfx_mem_data_bus_o     <= '0;
      gfx_mem_data_bus_oe    <= 1'b0;
      host_data_bus_o        <= host_rd_data;
      host_data_bus_oe       <= !host_read_b;
      vertical_sync_pin_oe   <= 1'b0;
      horizontal_sync_pin_oe <= 1'b0;
      odd_field_pin_oe       <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pins <= '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
    end else if (in_reset || state != RRS_ST_NORMAL) begin
      pins <= '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1}; // [R6]
    end else begin
      pins.display_period_out    <= display_period_out_period;
      pins.colour_detect_out     <= colour_hit;
      pins.dma_request_out       <= !dma_req;
      pins.interrupt_request_out <= !(|irq_flags); // [R13]
      pins.wait_out              <= !host_wait;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // normal operation, interrupts, colour packing
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      engine_run <= 1'b0;
    end else begin
      engine_run <= !in_reset && state == RRS_ST_NORMAL
                    && draw_active; // [R10]
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_flags <= '0;
    end else if (in_reset || state != RRS_ST_NORMAL) begin
      irq_flags <= '0;
    end else begin
      irq_flags <= (irq_flags & ~irq_clear) | irq_events; // [R13]
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pixel_out <= '0;
    end else begin
      pixel_out.red   <= yuv_rgb_in[23:19]; // [R14]
      pixel_out.green <= yuv_rgb_in[15:10]; // [R14]
      pixel_out.blue  <= yuv_rgb_in[7:3]; // [R14]
    end
  end

  // display unit gets derived dot clock; rest runs on clk
  rrs_clock_div #(
    .DIV (RRS_DOT_DIV)
  ) u_dot_div (
    .clk     (clk), // [R11]
    .rst_b   (rst_b),
    .run     (state == RRS_ST_NORMAL),
    .dot_clk (dot_clk)
  );

endmodule

// [verif/rrs_host_model.sv]
// Purpose: external system driving reset, mode pins, read strobe
// Assumes: bench changes requests at the falling edge
// Notes:   only the three legal mode patterns reach the pins
`timescale 1ns/1ns
module rrs_host_model
  import rrs_pkg::*;
(
  input  wire logic       hold_reset,
  input  wire logic [1:0] mode_sel,
  input  wire logic       read_req,
  output logic            reset_pin_b,
  output logic            op_select_pin0,
  output logic            op_select_pin1,
  output logic            op_select_pin2,
  output logic            host_read_b
);
  logic [2:0] mode;
  assign mode = (mode_sel == 2'h3) ? RRS_MODE_0 : {1'b0, mode_sel};
  assign {op_select_pin2, op_select_pin1, op_select_pin0} = mode;
  assign reset_pin_b = !hold_reset;
  assign host_read_b = !read_req;
endmodule

// [verif/rrs_state_props.sv]
// Purpose: port timing checks for reset/state control
// Assumes: one clock domain, reset pin sampled on clk
// Notes:   bound to the design from the bench top
`timescale 1ns/1ns
module rrs_state_props
  import rrs_pkg::*;
#(
  parameter int INIT_CYC = RRS_INIT_CYC
) (
  input wire logic                clk,
  input wire logic                rst_b,
  input wire logic                reset_pin_b,
  input wire logic                op_select_pin0,
  input wire logic                op_select_pin1,
  input wire logic                op_select_pin2,
  input wire logic                host_read_b,
  input wire logic                draw_active,
  input wire logic [23:0]         yuv_rgb_in,
  input wire rrs_state_e          state,
  input wire logic [2:0]          op_mode,
  input wire logic [RRS_MD_W-1:0] gfx_mem_data_bus_o,
  input wire logic                gfx_mem_data_bus_oe,
  input wire logic                host_data_bus_oe,
  input wire rrs_pins_s           pins,
  input wire logic                refresh_req,
  input wire logic                engine_run,
  input wire rrs_rgb_s            pixel_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire in_rst = (state == RRS_ST_RESET);
  wire pins_ok = !pins.display_period_out && !pins.colour_detect_out
    && pins.dma_request_out && pins.interrupt_request_out && pins.wait_out;
  sequence s_release; $rose(reset_pin_b) && in_rst; endsequence
  sequence s_init_start; $rose(state == RRS_ST_MEM_INIT); endsequence
  property p_no_refresh; !reset_pin_b ##1 !reset_pin_b |=> !refresh_req;
  endproperty
  a_no_refresh: assert property (p_no_refresh)
    else $error("refresh while reset held");
  property p_mem_low; in_rst |-> gfx_mem_data_bus_oe
    && gfx_mem_data_bus_o == 32'h0; endproperty
  a_mem_low: assert property (p_mem_low)
    else $error("memory bus not driven low in reset");
  property p_host_bus; in_rst |-> host_data_bus_oe == !$past(host_read_b);
  endproperty
  a_host_bus: assert property (p_host_bus)
    else $error("host bus enable wrong in reset");
  property p_pins; in_rst |-> pins_ok; endproperty
  a_pins: assert property (p_pins)
    else $error("pin levels wrong in reset");
  property p_capture; s_release |=> state == RRS_ST_MEM_INIT && op_mode ==
    $past({op_select_pin2, op_select_pin1, op_select_pin0}); endproperty
  a_capture: assert property (p_capture)
    else $error("mode not captured at reset release");
  // cycles spent in memory init, so long init counts need no long delay
  int init_len;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      init_len <= 0;
    end else if (state == RRS_ST_MEM_INIT) begin
      init_len <= init_len + 1;
    end else begin
      init_len <= 0;
    end
  end
  sequence s_init_end; (state == RRS_ST_MEM_INIT) ##1
    (state == RRS_ST_NORMAL); endsequence
  property p_init; s_init_end |-> init_len == INIT_CYC; endproperty
  a_init: assert property (p_init)
    else $error("memory init length wrong");
  property p_init_start; s_init_start |-> init_len == 0; endproperty
  a_init_start: assert property (p_init_start)
    else $error("memory init count not fresh");
  property p_init_max; state == RRS_ST_MEM_INIT |-> init_len < INIT_CYC;
  endproperty
  a_init_max: assert property (p_init_max)
    else $error("memory init overran");
  property p_run; state == RRS_ST_NORMAL && reset_pin_b |=>
    engine_run == $past(draw_active); endproperty
  a_run: assert property (p_run)
    else $error("engines do not follow draw request");
  property p_run_off; state != RRS_ST_NORMAL |=> !engine_run; endproperty
  a_run_off: assert property (p_run_off)
    else $error("engines run outside normal state");
  property p_pixel; $past(rst_b) |-> pixel_out == {$past(yuv_rgb_in[23:19]),
    $past(yuv_rgb_in[15:10]), $past(yuv_rgb_in[7:3])}; endproperty
  a_pixel: assert property (p_pixel)
    else $error("pixel packing wrong");
endmodule

// [verif/test_renderer_reset_state_control.sv]
// Purpose: bench for renderer reset and state control
// Assumes: init count 8 and refresh period 5 in simulation
// Notes:   inputs change at the falling edge
`timescale 1ns/1ns
module test_renderer_reset_state_control
  import rrs_pkg::*;
();
  localparam int INIT_N = 8;
  localparam int REF_N  = 5;
  logic        clk = 1'b0;
  logic        rst_b, hold_reset, read_req, rpin_b, rd_b, op0, op1, op2;
  logic        illegal, md_oe, hd_oe, vs_oe, hs_oe, of_oe, refresh, busy;
  logic        run, dot;
  logic [1:0]  mode_sel;
  logic [2:0]  op_mode;
  logic [4:0]  lv;
  logic [7:0]  ev, clr, flags;
  logic [15:0] hd_o;
  logic [23:0] yuv;
  logic [31:0] md_o;
  rrs_state_e  state;
  rrs_pins_s   pins;
  rrs_rgb_s    pix;
  int          fail_count, total_checks, cyc;
  rrs_host_model host (.hold_reset(hold_reset), .mode_sel(mode_sel),
    .read_req(read_req), .reset_pin_b(rpin_b), .op_select_pin0(op0),
    .op_select_pin1(op1), .op_select_pin2(op2), .host_read_b(rd_b));
  rrs_state_ctrl #(.INIT_CYC(INIT_N), .REFRESH_CYC(REF_N)) dut (.clk(clk),
    .rst_b(rst_b), .reset_pin_b(rpin_b), .op_select_pin0(op0),
    .op_select_pin1(op1), .op_select_pin2(op2), .host_read_b(rd_b),
    .host_rd_data(16'h1234), .irq_events(ev), .irq_clear(clr),
    .draw_active(lv[0]), .display_period_out_period(lv[1]), .colour_hit(lv[2]),
    .dma_req(lv[3]), .host_wait(lv[4]), .yuv_rgb_in(yuv), .state(state),
    .op_mode(op_mode), .mode_illegal(illegal), .gfx_mem_data_bus_o(md_o),
    .gfx_mem_data_bus_oe(md_oe), .host_data_bus_o(hd_o),
    .host_data_bus_oe(hd_oe), .vertical_sync_pin_oe(vs_oe),
    .horizontal_sync_pin_oe(hs_oe), .odd_field_pin_oe(of_oe), .pins(pins),
    .refresh_req(refresh), .mem_init_busy(busy), .engine_run(run),
    .dot_clk(dot), .irq_flags(flags), .pixel_out(pix));
  task test_done;
    if (fail_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task step(input int n);
    repeat (n) @(negedge clk);
  endtask
  task t_reset_state;
    lv = 5'h1f;
    step(2);
    chk(state, RRS_ST_RESET);
    chk({md_oe, md_o}, 33'h100000000);
    chk({hd_oe, vs_oe, hs_oe, of_oe}, 4'h0);
    chk(pins, 5'h07);
    chk({refresh, busy, run, dot}, 4'h0);
    read_req = 1;
    step(1);
    chk(hd_oe, 1'b1);
    read_req = 0;
    step(1);
    chk(hd_oe, 1'b0);
  endtask
  task t_mode(input logic [1:0] m);
    int n;
    int b;
    logic d;
    hold_reset = 1;
    mode_sel = m;
    step(2);
    hold_reset = 0;
    step(1);
    chk({illegal, op_mode}, {2'h0, m});
    chk(state, RRS_ST_MEM_INIT);
    chk(run, 1'b0);
    n = 0;
    b = 0;
    while (state === RRS_ST_MEM_INIT && n < 50) begin
      n++;
      if (busy === 1'b1) b++;
      step(1);
    end
    chk(n, INIT_N);
    chk(b, INIT_N - 1);
    chk(busy, 1'b0);
    chk(state, RRS_ST_NORMAL);
    n = 0;
    repeat (4 * REF_N) begin
      step(1);
      if (refresh === 1'b1) n++;
    end
    chk(n, 4);
    chk(run, 1'b1);
    chk(pins, 5'h1a);
    read_req = 1;
    step(1);
    chk({hd_oe, hd_o}, 17'h11234);
    read_req = 0;
    d = dot;
    step(1);
    chk(dot, !d);
  endtask
  task t_irq;
    for (int k = 0; k < RRS_IRQ_N; k++) begin
      ev = 8'h01 << k;
      step(1);
      ev = 8'h00;
      step(1);
      chk({flags, pins.interrupt_request_out}, {8'h01 << k, 1'b0});
      clr = 8'hff;
      step(1);
      clr = 8'h00;
      step(1);
      chk({flags, pins.interrupt_request_out}, 9'h001);
    end
    ev = 8'h80;
    clr = 8'h80;
    step(1);
    {ev, clr} = 16'h0000;
    step(1);
    chk(flags, 8'h80);
    hold_reset = 1;
    step(2);
    chk(flags, 8'h00);
  endtask
  task t_pixel;
    yuv = 24'ha5c33c;
    lv = 5'h00;
    step(1);
    chk(pix, {5'h14, 6'h30, 5'h07});
    chk({run, pins}, 6'h07);
  endtask
  initial begin
    clk = 0;
    forever #10 clk = !clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc > 3000) begin
      fail_count++;
      test_done();
    end
  end
  initial begin
    {rst_b, read_req, mode_sel, ev, clr, lv, yuv} = '0;
    hold_reset = 1;
    step(10);
    chk({state, pins}, {RRS_ST_POWER_ON, 5'h07});
    rst_b = 1;
    t_reset_state();
    for (int m = 0; m < 3; m++) t_mode(m[1:0]);
    t_pixel();
    t_irq();
    test_done();
  end
endmodule
bind rrs_state_ctrl rrs_state_props #(.INIT_CYC(INIT_CYC)) props (
  .clk(clk), .rst_b(rst_b), .reset_pin_b(reset_pin_b),
  .op_select_pin0(op_select_pin0), .op_select_pin1(op_select_pin1),
  .op_select_pin2(op_select_pin2), .host_read_b(host_read_b),
  .draw_active(draw_active),
  .yuv_rgb_in(yuv_rgb_in), .state(state), .op_mode(op_mode),
  .gfx_mem_data_bus_o(gfx_mem_data_bus_o),
  .gfx_mem_data_bus_oe(gfx_mem_data_bus_oe),
  .host_data_bus_oe(host_data_bus_oe), .pins(pins),
  .refresh_req(refresh_req), .engine_run(engine_run), .pixel_out(pixel_out));
